// ### src/tclut_pkg.sv
package tclut_pkg;

  // ==========================================================
  // Table map within the compensation serial page
  localparam logic [1:0] APC_TABLE_SEL = 2'h0;
  localparam logic [1:0] MOD_TABLE_SEL = 2'h1;
  localparam logic [1:0] FLT_TABLE_SEL = 2'h2;
  localparam logic [1:0] ALM_TABLE_SEL = 2'h3;
  localparam logic [7:0] APC_TABLE_BASE = 8'h00;
  localparam logic [7:0] MOD_TABLE_BASE = 8'h40;
  localparam logic [7:0] FLT_TABLE_BASE = 8'h80;
  localparam logic [7:0] ALM_TABLE_BASE = 8'hC0;
  localparam int TABLE_DEPTH = 64;
  localparam int PAGE_BYTES = 256;
  localparam logic [7:0] TABLE_ENTRY_RESET = 8'h00;

  // ==========================================================
  // Averaging and index arithmetic
  localparam int AVG_SAMPLES = 16;
  localparam int SUM_W = 12;
  localparam int POS_W = 11;
  localparam logic [7:0] FULL_SCALE_TEMP = 8'h7F;
  localparam logic [5:0] INDEX_MAX = 6'h3F;
  localparam logic [5:0] INDEX_RESET = 6'h00;
  localparam int DAC_W = 8;
  localparam logic [DAC_W-1:0] DAC_RESET = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [DAC_W-1:0] power_loop;
    logic [DAC_W-1:0] modulation;
    logic [DAC_W-1:0] bias_fault;
    logic [DAC_W-1:0] bias_alarm;
  } tclut_dac_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tclut_page_req_t;

  typedef enum logic [1:0] {
    ST_ACC,
    ST_INDEX,
    ST_LOAD
  } tclut_state_t;

endpackage

// ### src/tclut_engine.sv
`timescale 1ns/10ps
module tclut_engine
  import tclut_pkg::*;
#(
  parameter int SAMPLES = AVG_SAMPLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] temp_sample_in,
  input wire logic temp_valid_in,
  input wire logic sense_diode_fault_flag_in,
  input wire logic [7:0] table_range_shift_in,
  input wire logic comp_enable_in,
  input wire logic init_load_in,
  input wire tclut_dac_t nominal_in,
  input wire tclut_page_req_t page_req_in,
  output logic [7:0] page_rdata_out,
  output logic [5:0] table_index_readback_out,
  output tclut_dac_t dac_out,
  output logic dac_load_out
);

  localparam int AVG_SHIFT = $clog2(SAMPLES);

  // Refuse window lengths that the shift-based divide cannot serve
  if (SAMPLES < 2 || SAMPLES > AVG_SAMPLES || (1 << AVG_SHIFT) != SAMPLES) begin : g_bad_samples
    $error("SAMPLES must be a power of two from 2 to 16");
  end

  // ==========================================================
  // Functions
  function automatic logic [DAC_W-1:0] sat_add(input logic [DAC_W-1:0] nom, input logic [7:0] off);
    logic signed [DAC_W+1:0] s;
    s = $signed({2'b00, nom}) + $signed({{2{off[7]}}, off});
    if (s < 0) begin
      return '0;
    end else if (s > $signed({2'b00, {DAC_W{1'b1}}})) begin
      return {DAC_W{1'b1}};
    end else begin
      return s[DAC_W-1:0];
    end
  endfunction

  function automatic logic [5:0] clamp_index(input logic signed [POS_W-1:0] v);
    if (v < 0) begin
      return 6'h00;
    end else if (v > $signed({5'b00000, INDEX_MAX})) begin
      return INDEX_MAX;
    end else begin
      return v[5:0];
    end
  endfunction

  // Table base plus shared index gives the byte address in the page
  function automatic logic [7:0] fetch_addr(input logic [7:0] base, input logic [5:0] idx);
    return base + {2'b00, idx};
  endfunction

  // ==========================================================
  // Compensation page storage
  logic [7:0] page_mem_r [PAGE_BYTES];
  logic [7:0] page_rdata_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page_mem_r[i] <= TABLE_ENTRY_RESET;
      end
    end else if (page_req_in.wr) begin
      page_mem_r[page_req_in.addr] <= page_req_in.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      page_rdata_r <= 8'h00;
    end else if (page_req_in.rd) begin
      page_rdata_r <= page_mem_r[page_req_in.addr];
    end
  end

  assign page_rdata_out = page_rdata_r;

  // ==========================================================
  // SAMPLES-sample averaging (16 by default)
  logic [7:0] sample_eff;
  logic signed [SUM_W-1:0] sum_r;
  logic signed [SUM_W-1:0] sum_nxt;
  logic [AVG_SHIFT-1:0] cnt_r;
  logic signed [7:0] avg_r;
  logic avg_done_r;

  assign sample_eff = sense_diode_fault_flag_in ? FULL_SCALE_TEMP : temp_sample_in;
  assign sum_nxt = sum_r + $signed({{(SUM_W-8){sample_eff[7]}}, sample_eff});

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sum_r <= '0;
      cnt_r <= '0;
      avg_r <= '0;
      avg_done_r <= 1'b0;
    end else begin
      avg_done_r <= 1'b0;
      if (temp_valid_in) begin
        if (cnt_r == AVG_SHIFT'(SAMPLES - 1)) begin
          sum_r <= '0;
          cnt_r <= '0;
          avg_r <= 8'(sum_nxt >>> AVG_SHIFT);
          avg_done_r <= 1'b1;
        end else begin
          sum_r <= sum_nxt;
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Index calculation with clamping and hysteresis
  logic signed [POS_W-1:0] pos;
  logic signed [POS_W-1:0] raw_index;
  logic signed [POS_W-1:0] cur2;
  logic move_up;
  logic move_down;
  logic [5:0] index_r;
  logic index_valid_r;
  tclut_state_t state_r;

  // Position in table degrees; each range step shifts the span down two degrees
  assign pos = $signed({{(POS_W-8){avg_r[7]}}, avg_r}) + $signed({2'b00, table_range_shift_in, 1'b0});
  assign raw_index = pos >>> 1;
  assign cur2 = $signed({4'h0, index_r, 1'b0});
  assign move_up = pos >= cur2 + POS_W'(3);
  assign move_down = pos <= cur2 - POS_W'(2);

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      index_r <= INDEX_RESET;
      index_valid_r <= 1'b0;
    end else if (state_r == ST_INDEX) begin
      index_valid_r <= 1'b1;
      if (!index_valid_r || move_up || move_down) begin
        index_r <= clamp_index(raw_index);
      end
    end
  end

  assign table_index_readback_out = index_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_ACC;
    end else begin
      case (state_r)
        ST_ACC: begin
          if (avg_done_r) begin
            state_r <= ST_INDEX;
          end
        end
        ST_INDEX: begin
          state_r <= ST_LOAD;
        end
        ST_LOAD: begin
          state_r <= ST_ACC;
        end
        default: begin
          state_r <= ST_ACC;
        end
      endcase
    end
  end

  // ==========================================================
  // Table fetch and DAC loading
  logic [7:0] off_apc;
  logic [7:0] off_mod;
  logic [7:0] off_flt;
  logic [7:0] off_alm;
  logic load_now;
  tclut_dac_t dac_r;
  logic dac_load_r;

  // Offsets read as zero while compensation is disabled
  assign off_apc = comp_enable_in ? page_mem_r[fetch_addr(APC_TABLE_BASE, index_r)] : 8'h00;
  assign off_mod = comp_enable_in ? page_mem_r[fetch_addr(MOD_TABLE_BASE, index_r)] : 8'h00;
  assign off_flt = comp_enable_in ? page_mem_r[fetch_addr(FLT_TABLE_BASE, index_r)] : 8'h00;
  assign off_alm = comp_enable_in ? page_mem_r[fetch_addr(ALM_TABLE_BASE, index_r)] : 8'h00;

  // Initial load uses whatever index is current; disabled compensation gives nominal
  assign load_now = (state_r == ST_LOAD) || init_load_in;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dac_r <= '{default: DAC_RESET};
      dac_load_r <= 1'b0;
    end else begin
      dac_load_r <= load_now;
      if (load_now) begin
        dac_r.power_loop <= sat_add(nominal_in.power_loop, off_apc);
        dac_r.modulation <= sat_add(nominal_in.modulation, off_mod);
        dac_r.bias_fault <= sat_add(nominal_in.bias_fault, off_flt);
        dac_r.bias_alarm <= sat_add(nominal_in.bias_alarm, off_alm);
      end
    end
  end

  assign dac_out = dac_r;
  assign dac_load_out = dac_load_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  logic fault_all_r;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_all_r <= 1'b1;
    end else if (temp_valid_in && !sense_diode_fault_flag_in) begin
      fault_all_r <= 1'b0;
    end else if (avg_done_r) begin
      fault_all_r <= 1'b1;
    end
  end

  // Samples accepted since the last completed average
  localparam logic [AVG_SHIFT:0] WIN_FULL = SAMPLES[AVG_SHIFT:0];
  logic [AVG_SHIFT:0] win_samples_r;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_samples_r <= '0;
    end else if (avg_done_r) begin
      win_samples_r <= {{AVG_SHIFT{1'b0}}, temp_valid_in};
    end else if (temp_valid_in) begin
      win_samples_r <= win_samples_r + 1'b1;
    end
  end

  a_avg_after_window: assert property (
    avg_done_r |-> $past(temp_valid_in) && $past(cnt_r) == AVG_SHIFT'(SAMPLES - 1))
    else $error("average completed without a full sample window");

  a_refresh_sequence: assert property (
    state_r == ST_INDEX |=> state_r == ST_LOAD ##1 dac_load_out)
    else $error("average did not lead to a DAC refresh");

  a_index_top_clamp: assert property (
    state_r == ST_INDEX && raw_index > 63 && (move_up || !index_valid_r) |=> index_r == INDEX_MAX)
    else $error("index above range not clamped to top entry");

  a_index_bottom_clamp: assert property (
    state_r == ST_INDEX && raw_index < 0 && (move_down || !index_valid_r) |=> index_r == 6'h00)
    else $error("index below range not clamped to bottom entry");

  a_hyst_hold: assert property (
    state_r == ST_INDEX && index_valid_r && pos >= cur2 - POS_W'(1) && pos <= cur2 + POS_W'(2)
    |=> $stable(index_r))
    else $error("index moved inside hysteresis band");

  a_diode_full_scale: assert property (
    avg_done_r && $past(fault_all_r) && $past(sense_diode_fault_flag_in) |-> avg_r == FULL_SCALE_TEMP)
    else $error("diode fault did not force full scale average");

  a_nominal_when_off: assert property (
    load_now && !comp_enable_in |=> dac_out == $past(nominal_in) && dac_load_out)
    else $error("disabled compensation altered nominal values");

  a_host_write_store: assert property (
    page_req_in.wr ##1 page_req_in.rd && page_req_in.addr == $past(page_req_in.addr) && !page_req_in.wr
    |=> page_rdata_out == $past(page_req_in.wdata, 2))
    else $error("table write not read back");

  a_sat_top: assert property (
    load_now && comp_enable_in && nominal_in.power_loop == 8'hFF && !off_apc[7] |=> dac_out.power_loop == 8'hFF)
    else $error("setpoint sum wrapped instead of saturating");

  a_window_sample_count: assert property (
    avg_done_r |-> win_samples_r == WIN_FULL)
    else $error("average completed after a wrong number of samples");

  a_avg_single_pulse: assert property (
    avg_done_r |=> !avg_done_r)
    else $error("average strobe longer than one cycle");

  a_index_held: assert property (
    state_r != ST_INDEX |=> $stable(index_r))
    else $error("index changed without a new average");

  a_dac_held: assert property (
    !load_now |=> $stable(dac_out))
    else $error("DAC codes changed without a refresh");

  a_load_from_request: assert property (
    dac_load_out |-> $past(load_now))
    else $error("DAC load strobe without a refresh");

  a_index_follows_raw: assert property (
    state_r == ST_INDEX && (!index_valid_r || move_up || move_down) && raw_index >= 0 && raw_index <= 63
    |=> index_r == $past(raw_index[5:0]))
    else $error("index does not follow halved average plus range shift");

  a_offset_applied: assert property (
    load_now && comp_enable_in && !off_apc[7] && nominal_in.power_loop <= 8'hFF - off_apc
    |=> dac_out.power_loop == $past(nominal_in.power_loop) + $past(off_apc))
    else $error("setpoint offset not added to nominal");

  a_fault_offset_sum: assert property (
    load_now && comp_enable_in && !off_flt[7] && nominal_in.bias_fault <= 8'hFF - off_flt
    |=> dac_out.bias_fault == $past(nominal_in.bias_fault) + $past(off_flt))
    else $error("fault threshold offset not added to nominal");

  a_alarm_offset_sum: assert property (
    load_now && comp_enable_in && off_alm[7] && nominal_in.bias_alarm >= 8'(~off_alm + 8'h01)
    |=> dac_out.bias_alarm == 8'($past(nominal_in.bias_alarm) + $past(off_alm)))
    else $error("negative alarm offset not applied as signed");

  a_sat_bottom: assert property (
    load_now && comp_enable_in && off_mod[7] && nominal_in.modulation < 8'(~off_mod + 8'h01)
    |=> dac_out.modulation == 8'h00)
    else $error("modulation sum wrapped instead of saturating");

  a_rdata_host_only: assert property (
    !page_req_in.rd |=> $stable(page_rdata_out))
    else $error("host read data changed without a host read");

  c_average_done: cover property (avg_done_r ##2 dac_load_out);
  c_index_moves: cover property (state_r == ST_INDEX && index_valid_r && move_up);
  c_clamped_top: cover property (state_r == ST_INDEX && raw_index > 63);
  c_init_load: cover property (init_load_in && comp_enable_in);
  c_write_then_read: cover property (page_req_in.wr ##1 page_req_in.rd);

endmodule

// ### tb/tclut_host.sv
`timescale 1ns/10ps
module tclut_host
  import tclut_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [7:0] page_rdata_in,
  output tclut_page_req_t page_req_out
);
  initial page_req_out = '0;
  // ==========================================================
  // Page byte access, released address shows inverted value; released data is ~d after put, 8'h5A otherwise
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_in);
    page_req_out = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge sys_clk_in);
    page_req_out = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  // Write immediately followed by a read of the same byte
  task automatic put_get(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk_in);
    page_req_out = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge sys_clk_in);
    page_req_out = '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b1};
    @(negedge sys_clk_in);
    page_req_out = '{addr: ~a, wdata: 8'h5A, wr: 1'b0, rd: 1'b0};
    q = page_rdata_in;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    page_req_out = '{addr: a, wdata: 8'hA5, wr: 1'b0, rd: 1'b1};
    @(negedge sys_clk_in);
    page_req_out = '{addr: ~a, wdata: 8'h5A, wr: 1'b0, rd: 1'b0};
    d = page_rdata_in;
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import tclut_pkg::*;
  logic sys_clk_in, rst_in, temp_valid_in, fault_in, comp_enable_in, init_load_in, dac_load_out;
  logic [7:0] temp_sample_in, shift_in, page_rdata_out, rd;
  logic [5:0] idx;
  tclut_dac_t nominal_in, dac_out;
  tclut_page_req_t page_req;
  int err_count, num_checks;
  tclut_engine #(.SAMPLES(2)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .temp_sample_in(temp_sample_in),
    .temp_valid_in(temp_valid_in), .sense_diode_fault_flag_in(fault_in), .table_range_shift_in(shift_in),
    .comp_enable_in(comp_enable_in), .init_load_in(init_load_in), .nominal_in(nominal_in),
    .page_req_in(page_req), .page_rdata_out(page_rdata_out), .table_index_readback_out(idx),
    .dac_out(dac_out), .dac_load_out(dac_load_out));
  tclut_host host (.sys_clk_in(sys_clk_in), .page_rdata_in(page_rdata_out), .page_req_out(page_req));
  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Two-sample window, returns at the negedge after the output load
  task automatic window(input logic [7:0] a, input logic [7:0] b);
    @(negedge sys_clk_in);
    temp_valid_in = 1'b1;
    temp_sample_in = a;
    @(negedge sys_clk_in);
    temp_sample_in = b;
    @(negedge sys_clk_in);
    temp_valid_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check(idx, 0);
    check(dac_out, 0);
    host.get(8'h00, rd);
    check(rd, 0);
    host.get(8'hFF, rd);
    check(rd, 0);
  endtask
  task automatic t_average();
    host.put(8'h0A, 8'h05);
    host.put(8'h8A, 8'h7F);
    host.put(8'hCA, 8'h80);
    host.put_get(8'h4A, 8'hFD, rd);
    check(rd, 8'hFD);
    host.get(8'h4A, rd);
    check(rd, 8'hFD);
    window(8'h14, 8'h15);
    check(dac_load_out, 1);
    check(idx, 6'h0A);
    check(dac_out, 32'h1500FF10);
    @(negedge sys_clk_in);
    check(dac_load_out, 0);
    host.get(8'hCA, rd);
    check(rd, 8'h80);
  endtask
  task automatic t_hyst();
    window(8'h16, 8'h16);
    check(idx, 6'h0A);
    check(dac_out, 32'h1500FF10);
    window(8'h17, 8'h17);
    check(idx, 6'h0B);
    check(dac_out, 32'h1002F090);
  endtask
  task automatic t_clamp();
    fault_in = 1'b1;
    window(8'h00, 8'h00);
    check(idx, 6'h3F);
    fault_in = 1'b0;
    window(8'hD8, 8'hD8);
    check(idx, 6'h00);
    shift_in = 8'h0F;
    window(8'hE6, 8'hE6);
    check(idx, 6'h02);
    window(8'h64, 8'h64);
    check(idx, 6'h3F);
    check(dac_out, 32'h1002F090);
  endtask
  task automatic t_init();
    host.put(8'h3F, 8'h05);
    comp_enable_in = 1'b0;
    init_load_in = 1'b1;
    @(negedge sys_clk_in);
    init_load_in = 1'b0;
    check(dac_load_out, 1);
    check(dac_out, 32'h1002F090);
    @(negedge sys_clk_in);
    comp_enable_in = 1'b1;
    init_load_in = 1'b1;
    @(negedge sys_clk_in);
    init_load_in = 1'b0;
    check(dac_out, 32'h1502F090);
    @(negedge sys_clk_in);
    nominal_in = 32'hFF02F090;
    init_load_in = 1'b1;
    @(negedge sys_clk_in);
    init_load_in = 1'b0;
    check(dac_out, 32'hFF02F090);
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    err_count = 0;
    num_checks = 0;
    rst_in = 1'b1;
    temp_valid_in = 1'b0;
    fault_in = 1'b0;
    comp_enable_in = 1'b1;
    init_load_in = 1'b0;
    temp_sample_in = 8'h00;
    shift_in = 8'h00;
    nominal_in = 32'h1002F090;
    repeat (3) @(negedge sys_clk_in);
    rst_in = 1'b0;
    t_reset();
    t_average();
    t_hyst();
    t_clamp();
    t_init();
    tally_and_finish();
  end
endmodule
